// >>> rtl/cfpd_core.sv
`timescale 1ns/1ps
`include "cfpd_regs.svh"
module cfpd_core
   import cfpd_pkg::*;
#(
   parameter logic [19:0] RESET_PC = `CFPD_RESET_PC,
   parameter logic [19:0] RESET_SP = `CFPD_RESET_SP
) (
   input  wire logic          clk,
   input  wire logic          rst,
   output cfpd_mem_req_t      memOut,
   input  wire logic          memAck,
   input  wire logic [15:0]   memRdata,
   input  wire logic          memVacant,
   input  wire logic          irqPending,
   input  wire logic          vacantIrqEnable,
   input  wire logic          vacantFlagClear,
   output logic               vacantAccessFlag,
   output logic               vacantIrq,
   output logic               coreHung,
   output cfpd_retire_t       retire,
   output logic [15:0]        statusWord,
   input  wire logic [3:0]    dbgRegSel,
   output logic [19:0]        dbgRegData
);
   cfpd_state_t   state;
   cfpd_state_t   next_state;
   cfpd_mem_req_t next_memOut;
   cfpd_retire_t  next_retire;
   logic [19:0]   pc;
   logic [19:0]   next_pc;
   logic [19:0]   sp;
   logic [19:0]   next_sp;
   logic [15:0]   next_statusWord;
   logic [15:0]   inst;
   logic [15:0]   next_inst;
   logic [19:0]   jumpTarget;
   logic [19:0]   next_jumpTarget;
   logic          skipNext;
   logic          next_skipNext;
   logic [3:0]    popCnt;
   logic [3:0]    next_popCnt;
   logic [3:0]    popReg;
   logic [3:0]    next_popReg;
   logic          popHigh;
   logic          next_popHigh;
   logic          popWide;
   logic          next_popWide;
   logic [15:0]   popLow;
   logic [15:0]   next_popLow;
   logic          flagSet;
   logic          rfWe;
   logic [3:0]    rfWaddr;
   logic [19:0]   rfWdata;
   logic          next_flag;

   function automatic logic cond_taken(input logic [2:0] cc, input logic [15:0] stw);
      logic t;
      t = 1'b1;
      case (cc)
         3'h0:    t = ~stw[`CFPD_STW_ZERO];
         3'h1:    t = stw[`CFPD_STW_ZERO];
         3'h2:    t = ~stw[`CFPD_STW_CARRY];
         3'h3:    t = stw[`CFPD_STW_CARRY];
         default: t = 1'b1;
      endcase
      return t;
   endfunction

   // decode of the fetched word
   wire logic        isJump   = inst[15:13] == `CFPD_JUMP_TOP;
   wire logic        jumpGo   = cond_taken(inst[12:10], statusWord);
   wire logic [19:0] jumpDest = pc + {{9{inst[9]}}, inst[9:0], 1'b0};
   wire logic        isFmt1   = inst[15:14] != 2'h0;
   wire logic        isPcInd  = isFmt1 && inst[11:8] == `CFPD_PC_INDEX && inst[5:4] == `CFPD_AS_INDIRECT;
   wire logic        isPopA   = inst[15:8] == `CFPD_POP_ADDR_OP;
   wire logic        isPopW   = inst[15:8] == `CFPD_POP_WORD_OP;
   wire logic [3:0]  popFirst = inst[3:0] - inst[7:4];
   // the peek ignores the x nibble, so data words trip it as well as opcodes
   wire logic        peekHit  = (memRdata & `CFPD_PEEK_MASK) == `CFPD_PEEK_VAL_A
                             || (memRdata & `CFPD_PEEK_MASK) == `CFPD_PEEK_VAL_B;
   wire logic        memState = state == ST_FETCH || state == ST_JPEEK || state == ST_OPND
                             || state == ST_POP || state == ST_POPX;
   wire logic [19:0] stateAddr = (state == ST_POP || state == ST_POPX) ? sp : pc;
   wire logic        memDone  = memOut.req && memAck;
   wire logic [19:0] popValue = popWide ? {memRdata[3:0], popLow} : {4'h0, memRdata};
   wire logic        stwLowPower = popValue[`CFPD_STW_LOWPWR];

   always_comb begin
      next_state      = state;
      next_memOut     = memOut;
      next_retire     = '{done: 1'b0, pc: retire.pc};
      next_pc         = pc;
      next_sp         = sp;
      next_statusWord = statusWord;
      next_inst       = inst;
      next_jumpTarget = jumpTarget;
      next_skipNext   = skipNext;
      next_popCnt     = popCnt;
      next_popReg     = popReg;
      next_popHigh    = popHigh;
      next_popWide    = popWide;
      next_popLow     = popLow;
      flagSet         = 1'b0;
      rfWe            = 1'b0;
      rfWaddr         = 4'h0;
      rfWdata         = 20'h00000;
      if (memState && !memOut.req) begin
         next_memOut = '{req: 1'b1, addr: stateAddr};
      end
      if (memDone) begin
         next_memOut.req = 1'b0;
      end
      unique case (state)
         ST_FETCH: begin
            if (memDone) begin
               next_inst  = memRdata;
               next_pc    = pc + `CFPD_PC_STEP;
               next_state = ST_DECODE;
            end
         end
         ST_DECODE: begin
            next_state = ST_FETCH;
            if (skipNext) begin
               next_skipNext = 1'b0;
            end else if (isJump && jumpGo) begin
               next_jumpTarget = jumpDest;
               next_state      = ST_JPEEK;
            end else if (isPcInd) begin
               next_state = ST_OPND;
            end else if (isPopA || isPopW) begin
               next_popCnt  = inst[7:4];
               next_popReg  = popFirst;
               next_popHigh = 1'b0;
               next_popWide = isPopA;
               next_state   = ST_POP;
            end else begin
               next_retire = '{done: 1'b1, pc: pc - `CFPD_PC_STEP};
            end
         end
         ST_JPEEK: begin
            if (memDone) begin
               next_pc     = peekHit ? jumpTarget + `CFPD_JUMP_EXTRA : jumpTarget;
               next_retire = '{done: 1'b1, pc: pc - `CFPD_PC_STEP};
               next_state  = ST_FETCH;
            end
         end
         ST_OPND: begin
            if (memDone) begin
               rfWe    = 1'b1;
               rfWaddr = inst[3:0];
               rfWdata = {4'h0, memRdata};
               if (inst[3:0] == `CFPD_STW_INDEX) begin
                  next_statusWord = memRdata;
               end
               next_skipNext = 1'b1;
               next_retire   = '{done: 1'b1, pc: pc - `CFPD_PC_STEP};
               next_state    = ST_FETCH;
            end
         end
         ST_POP: begin
            if (memDone) begin
               next_sp = sp + `CFPD_PC_STEP;
               if (popWide && !popHigh) begin
                  next_popLow  = memRdata;
                  next_popHigh = 1'b1;
               end else begin
                  rfWe    = 1'b1;
                  rfWaddr = popReg;
                  rfWdata = popValue;
                  next_popHigh = 1'b0;
                  next_popReg  = popReg + 4'h1;
                  next_popCnt  = popCnt - 4'h1;
                  if (popReg == `CFPD_STW_INDEX) begin
                     next_statusWord = popValue[15:0];
                  end
                  if (popReg == `CFPD_STW_INDEX && stwLowPower && irqPending) begin
                     next_state = ST_HANG;
                  end else if (popCnt == 4'h0) begin
                     next_state = ST_POPX;
                  end
               end
            end
         end
         ST_POPX: begin
            // stray read at the stack pointer left by the last increment
            if (memDone) begin
               flagSet     = memVacant;
               next_retire = '{done: 1'b1, pc: pc - `CFPD_PC_STEP};
               next_state  = ST_FETCH;
            end
         end
         ST_HANG: begin
            // only reset leaves this state
            next_memOut = '{req: 1'b0, addr: memOut.addr};
         end
      endcase
   end

   // set beats a clear in the same cycle
   assign next_flag = flagSet | (vacantAccessFlag & ~vacantFlagClear);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state            <= ST_FETCH;
         memOut           <= '{req: 1'b0, addr: 20'h00000};
         retire           <= '{done: 1'b0, pc: 20'h00000};
         pc               <= RESET_PC;
         sp               <= RESET_SP;
         statusWord       <= `CFPD_RESET_STW;
         inst             <= 16'h0000;
         jumpTarget       <= 20'h00000;
         skipNext         <= 1'b0;
         popCnt           <= 4'h0;
         popReg           <= 4'h0;
         popHigh          <= 1'b0;
         popWide          <= 1'b0;
         popLow           <= 16'h0000;
      end else begin
         state            <= next_state;
         memOut           <= next_memOut;
         retire           <= next_retire;
         pc               <= next_pc;
         sp               <= next_sp;
         statusWord       <= next_statusWord;
         inst             <= next_inst;
         jumpTarget       <= next_jumpTarget;
         skipNext         <= next_skipNext;
         popCnt           <= next_popCnt;
         popReg           <= next_popReg;
         popHigh          <= next_popHigh;
         popWide          <= next_popWide;
         popLow           <= next_popLow;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vacantAccessFlag <= 1'b0;
         vacantIrq        <= 1'b0;
         coreHung         <= 1'b0;
      end else begin
         vacantAccessFlag <= next_flag;
         vacantIrq        <= next_flag & vacantIrqEnable;
         coreHung         <= next_state == ST_HANG;
      end
   end

   cfpd_regfile #(
      .WIDTH (20),
      .DEPTH (16),
      .AW    (4)
   ) u_regfile (
      .clk    (clk),
      .rst    (rst),
      .wrEn   (rfWe),
      .wrAddr (rfWaddr),
      .wrData (rfWdata),
      .rdAddr (dbgRegSel),
      .rdData (dbgRegData)
   );
endmodule

// >>> rtl/cfpd_pkg.sv
package cfpd_pkg;

   typedef struct packed {
      logic        req;
      logic [19:0] addr;
   } cfpd_mem_req_t;

   typedef struct packed {
      logic        done;
      logic [19:0] pc;
   } cfpd_retire_t;

   typedef enum logic [2:0] {
      ST_FETCH,
      ST_DECODE,
      ST_JPEEK,
      ST_OPND,
      ST_POP,
      ST_POPX,
      ST_HANG
   } cfpd_state_t;

endpackage

// >>> rtl/cfpd_regfile.sv
`timescale 1ns/1ps
module cfpd_regfile #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             wrEn,
   input  wire logic [AW-1:0]    wrAddr,
   input  wire logic [WIDTH-1:0] wrData,
   input  wire logic [AW-1:0]    rdAddr,
   output logic      [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // registered read; a same-cycle write shows one cycle later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdData <= '0;
      end else begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

// >>> rtl/cfpd_regs.svh
// Contract
// - pending irq plus pop setting the low-power bit in the status word hangs
// - pc indirect source skips the following instruction
// - taken jump followed by 0x40/0x50 pattern adds two
// - multi pop makes one extra read afterwards, none when it hangs
// - vacant extra read sets flag, maybe interrupt
`ifndef CFPD_REGS_SVH
`define CFPD_REGS_SVH

`define CFPD_ADDR_W        20
`define CFPD_DATA_W        16
`define CFPD_PC_STEP       20'h00002
`define CFPD_JUMP_EXTRA    20'h00002
`define CFPD_RESET_PC      20'h04400
`define CFPD_RESET_SP      20'h02400
`define CFPD_RESET_STW     16'h0000
// jump: top three bits 001, condition in 12:10, word offset in 9:0
`define CFPD_JUMP_TOP      3'h1
// word after a jump that trips the pc advance, x nibble masked
`define CFPD_PEEK_MASK     16'hf0ff
`define CFPD_PEEK_VAL_A    16'h0040
`define CFPD_PEEK_VAL_B    16'h0050
// multi pop: 15:8 selects width, 7:4 count minus one, 3:0 last register
`define CFPD_POP_ADDR_OP   8'h16
`define CFPD_POP_WORD_OP   8'h17
// status word register index and its bits
`define CFPD_STW_INDEX     4'h2
`define CFPD_STW_CARRY     0
`define CFPD_STW_ZERO      1
`define CFPD_STW_LOWPWR    4
// indirect source mode code in bits 5:4
`define CFPD_AS_INDIRECT   2'h2
`define CFPD_PC_INDEX      4'h0

`endif

// >>> sim/cfpd_checker.sv
`timescale 1ns/1ps
module cfpd_checker
   import cfpd_pkg::*;
(
   input wire logic          clk,
   input wire logic          rst,
   input wire cfpd_mem_req_t memOut,
   input wire logic          memAck,
   input wire logic          memVacant,
   input wire logic          irqPending,
   input wire logic          vacantIrqEnable,
   input wire logic          vacantFlagClear,
   input wire logic          vacantAccessFlag,
   input wire logic          vacantIrq,
   input wire logic          coreHung,
   input wire cfpd_retire_t  retire
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_req_holds: assert property (memOut.req && !memAck |=> memOut.req && $stable(memOut.addr))
      else $error("read request dropped early");
   a_req_drops: assert property (memOut.req && memAck |=> !memOut.req)
      else $error("read request kept after answer");
   a_hang_cause: assert property ($rose(coreHung) |-> $past(irqPending) && $past(memAck))
      else $error("hang without pending request");
   a_hang_stays: assert property (coreHung |=> coreHung && !memOut.req)
      else $error("hung core left hang");
   a_hang_quiet: assert property (coreHung |-> !retire.done)
      else $error("hung core retired");
   a_flag_cause: assert property ($rose(vacantAccessFlag) |->
      ($past(memAck) && $past(memVacant)) || ($past(memAck, 2) && $past(memVacant, 2)))
      else $error("flag set without vacant read");
   a_flag_sticky: assert property (vacantAccessFlag && !vacantFlagClear |=> vacantAccessFlag)
      else $error("flag lost without clear");
   a_irq_match: assert property (vacantIrq == (vacantAccessFlag && $past(vacantIrqEnable)))
      else $error("vacant irq disagrees with flag");
   c_hang: cover property ($rose(coreHung));
   c_irq: cover property ($rose(vacantIrq));
   c_vacant: cover property (memOut.req && memAck && memVacant);
endmodule
bind cfpd_core cfpd_checker u_chk (.clk(clk), .rst(rst), .memOut(memOut), .memAck(memAck),
   .memVacant(memVacant), .irqPending(irqPending), .vacantIrqEnable(vacantIrqEnable),
   .vacantFlagClear(vacantFlagClear), .vacantAccessFlag(vacantAccessFlag),
   .vacantIrq(vacantIrq), .coreHung(coreHung), .retire(retire));

// >>> sim/cfpd_mem_model.sv
`timescale 1ns/1ps
module cfpd_mem_model
   import cfpd_pkg::*;
(
   input  wire logic          clk,
   input  wire cfpd_mem_req_t memOut,
   output logic               memAck,
   output logic [15:0]        memRdata,
   output logic               memVacant,
   input  wire logic [19:0]   vacantBase,
   input  wire logic [1:0]    waitCycles
);
   logic [15:0] mem [logic [19:0]];
   logic [19:0] rdLog [$];
   int          cnt = 0;
   initial memAck = 1'b0;
   initial memRdata = 16'h0000;
   initial memVacant = 1'b0;
   // vacant window is four bytes wide so code space stays valid
   always @(negedge clk) begin
      if (memAck || !memOut.req) begin
         memAck <= 1'b0;
         memVacant <= 1'b0;
         memRdata <= ~memRdata; // idle bus never repeats the last word
         cnt <= 0;
      end else if (cnt >= waitCycles) begin
         memAck <= 1'b1;
         memVacant <= memOut.addr[19:2] == vacantBase[19:2];
         memRdata <= mem.exists(memOut.addr) ? mem[memOut.addr] : 16'h4303;
         rdLog.push_back(memOut.addr);
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule

// >>> sim/test_cpu_fetch_and_pop_defects.sv
`timescale 1ns/1ps
module test_cpu_fetch_and_pop_defects;
   import cfpd_pkg::*;
   logic          clk = 1'b0;
   logic          rst = 1'b1;
   cfpd_mem_req_t memOut;
   logic          memAck, memVacant, vacantAccessFlag, vacantIrq, coreHung;
   logic [15:0]   memRdata, statusWord;
   logic          irqPending = 1'b0;
   logic          vacantIrqEnable = 1'b0;
   logic          vacantFlagClear = 1'b0;
   logic [3:0]    dbgRegSel = 4'h0;
   logic [19:0]   dbgRegData;
   logic [19:0]   vacantBase = 20'hffffc;
   logic [1:0]    waitCycles = 2'h0;
   cfpd_retire_t  retire;
   logic [19:0]   rets [$];
   int            errCount = 0;
   int            nTests = 0;
   cfpd_core u_dut (.clk(clk), .rst(rst), .memOut(memOut), .memAck(memAck), .memRdata(memRdata),
      .memVacant(memVacant), .irqPending(irqPending), .vacantIrqEnable(vacantIrqEnable),
      .vacantFlagClear(vacantFlagClear), .vacantAccessFlag(vacantAccessFlag), .vacantIrq(vacantIrq),
      .coreHung(coreHung), .retire(retire), .statusWord(statusWord), .dbgRegSel(dbgRegSel),
      .dbgRegData(dbgRegData));
   cfpd_mem_model u_mem (.clk(clk), .memOut(memOut), .memAck(memAck), .memRdata(memRdata),
      .memVacant(memVacant), .vacantBase(vacantBase), .waitCycles(waitCycles));
   always #2 clk = ~clk;
   always @(posedge clk) if (retire.done === 1'b1) rets.push_back(retire.pc);
   task automatic check(input logic [19:0] seen, input logic [19:0] exp);
      nTests++;
      if (seen !== exp) begin
         errCount++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic restart(input logic [19:0] vb);
      @(negedge clk);
      rst = 1'b1;
      vacantBase = vb;
      repeat (10) @(negedge clk);
      // logs cleared late: the model may still log a read on the edge reset rises
      rets.delete();
      u_mem.rdLog.delete();
      u_mem.mem.delete();
   endtask
   // release reset, then wait for k retirements under a bound
   task automatic go(input int k);
      rst = 1'b0;
      for (int i = 0; i < 200 && rets.size() < k; i++) @(negedge clk);
   endtask
   task automatic t_jump;
      logic [15:0] jo [4] = '{16'h3c04, 16'h2004, 16'h3c04, 16'h2404};
      logic [15:0] pk [4] = '{16'h0140, 16'h0150, 16'h4303, 16'h0140};
      logic [19:0] ex [4] = '{20'h0440c, 20'h0440c, 20'h0440a, 20'h04402};
      // last case is a conditional jump not taken: no peek, plain fall-through
      for (int j = 0; j < 4; j++) begin
         restart(20'hffffc);
         waitCycles = 2'(j);
         u_mem.mem[20'h04400] = jo[j];
         u_mem.mem[20'h04402] = pk[j];
         go(2);
         check(rets[0], 20'h04400);
         check(rets[1], ex[j]);
      end
      $display("jump test done");
   endtask
   task automatic t_pcind;
      restart(20'hffffc);
      dbgRegSel = 4'h7;
      u_mem.mem[20'h04400] = 16'h4027;
      u_mem.mem[20'h04402] = 16'h1234;
      go(2);
      check(rets[1], 20'h04404);
      check(dbgRegData, 20'h01234);
      $display("pc indirect test done");
   endtask
   task automatic t_pop;
      logic [15:0] op [4] = '{16'h1715, 16'h1715, 16'h1606, 16'h1705};
      // third case keeps the stack top 4 bytes above the data
      logic [19:0] vb [4] = '{20'h02404, 20'h02404, 20'h02408, 20'h02404};
      logic [19:0] rv [4] = '{20'h00002, 20'h00002, 20'h21111, 20'h01111};
      logic [19:0] xa [4] = '{20'h02404, 20'h02404, 20'h02404, 20'h02402};
      int          xi [4] = '{3, 3, 3, 2};
      for (int p = 0; p < 4; p++) begin
         restart(vb[p]);
         vacantIrqEnable = (p == 0);
         dbgRegSel = op[p][3:0];
         u_mem.mem[20'h04400] = op[p];
         u_mem.mem[20'h02400] = 16'h1111;
         u_mem.mem[20'h02402] = 16'h0002;
         // last restore by a single pop, so the multi pop stops short of the top
         if (p == 3) u_mem.mem[20'h04402] = 16'h4134;
         go(2);
         check(u_mem.rdLog[xi[p]], xa[p]);
         check(dbgRegData, rv[p]);
         check(vacantAccessFlag, p < 2);
         check(vacantIrq, p == 0);
         vacantFlagClear = 1'b1;
         @(negedge clk);
         vacantFlagClear = 1'b0;
         @(negedge clk);
         check(vacantAccessFlag, 1'b0);
         check(vacantIrq, 1'b0);
      end
      $display("multi pop test done");
   endtask
   task automatic t_hang;
      for (int h = 0; h < 2; h++) begin
         restart(20'hffffc);
         irqPending = h[0];
         u_mem.mem[20'h04400] = 16'h1702;
         u_mem.mem[20'h02400] = 16'h0010;
         go(2);
         check(coreHung, h[0]);
         if (h == 1) check(20'(u_mem.rdLog.size()), 20'h2);
         else check(statusWord, 16'h0010);
      end
      irqPending = 1'b0;
      $display("hang test done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      t_jump();
      t_pcind();
      t_pop();
      t_hang();
      summarize();
   end
   initial begin
      #40000;
      errCount++;
      summarize();
   end
endmodule
